// ### hdl/twu_master_tx.sv
/*
 * Two-wire master transmitter with APB register access.
 * Holds the control, status, data and mode registers and the bus
 * sequencer for START, address, data bytes, repeated START and STOP.
 * Assumes open-drain pads outside: an enable high pulls the line low.
 */
// Our own choices: the register offsets and the APB interface to the registers.
// Notes on behaviour
// - software chooses which of the four modes may be used
// - while the done flag is set the bus transfer is suspended
// - START first; the address byte direction bit picks the master mode
// - start request with flag write and enable sends START once bus free
// - after START the flag sets with status 0x08
// - after address and acknowledge the flag sets with 0x18, 0x20 or 0x38
// - data writes while the flag is low are dropped and flag a collision
// - stop request with flag write sends a STOP condition
// - writing one clears the flag; the unit runs only when enabled
// - read bit and not-acknowledge are high, write bit and acknowledge low
// - each packet is eight data bits then one acknowledge bit
// - after each data byte and acknowledge the flag sets with status
// - scl is held low while the done flag is set, except after lost arbitration
// - no done flag after a STOP condition
// - the stop request clears itself once STOP has gone out
// - lost arbitration gives 0x38, releases bus, retries if start set
`timescale 1ns/1ps
`default_nettype none

module twu_master_tx
    import twu_pkg::*;
(
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // bus pins, open drain
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // interrupt request
    output logic o_irq
);

    twu_ctrl_s ctrl;
    twu_state_e state;
    logic [7:0] data;
    logic [3:0] permit;
    logic [3:0] cur_mode;
    logic [4:0] code;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [9:0] timer;
    logic [1:0] step;
    logic scl_low;
    logic sda_low;
    logic ev_done;
    logic ev_stop;
    logic addr_byte;
    logic rep;
    logic ack;
    logic scl_in;
    logic sda_in;
    logic scl_prev;
    logic sda_prev;
    logic bus_busy;
    logic tick;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic master_ok;
    logic data_wr;

    // pin synchronisers
    twu_pin_sync u_scl_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_pin(i_scl),
        .o_level(scl_in)
    );

    twu_pin_sync u_sda_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_pin(i_sda),
        .o_level(sda_in)
    );

    // apb decode; one wait-free access phase while enabled
    assign wr = i_psel && i_penable && i_pwrite && i_ce;
    assign rd_setup = i_psel && !i_penable && i_ce;
    assign mapped = (i_paddr == TWU_OFF_CTRL) || (i_paddr == TWU_OFF_STATUS)
        || (i_paddr == TWU_OFF_DATA) || (i_paddr == TWU_OFF_MODE);
    assign o_pready = i_ce;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign data_wr = wr && (i_paddr == TWU_OFF_DATA);
    assign tick = (timer == 10'h000);
    // master modes only when software allowed one
    assign master_ok = permit[TWU_MODE_MT] || permit[TWU_MODE_MR];

    // pads only ever pull low
    assign o_scl = 1'b0;
    assign o_sda = 1'b0;
    assign o_scl_oe = scl_low;
    assign o_sda_oe = sda_low;
    // request while flag and enable both set
    assign o_irq = ctrl.done && ctrl.irq_enable;

    // read data is taken in the setup phase so it comes from a flop
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (i_paddr)
                TWU_OFF_CTRL: o_prdata <= {24'h00_0000, ctrl};
                // code sits in the upper five bits
                TWU_OFF_STATUS: o_prdata <= {24'h00_0000, code, 3'b000};
                TWU_OFF_DATA: o_prdata <= {24'h00_0000, data};
                TWU_OFF_MODE: o_prdata <= {24'h00_0000, cur_mode, permit};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // control, data and mode registers; hardware sets win over clears
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl <= TWU_CTRL_RST;
            data <= TWU_DATA_RST;
            permit <= TWU_PERMIT_RST;
        end else if (i_ce) begin
            if (ev_stop) begin
                ctrl.stop <= 1'b0;
            end
            if (wr && (i_paddr == TWU_OFF_CTRL)) begin
                // one clears the flag, zero leaves it
                if (i_pwdata[7]) begin
                    ctrl.done <= 1'b0;
                end
                ctrl.ack_enable <= i_pwdata[6];
                ctrl.start <= i_pwdata[5];
                ctrl.stop <= i_pwdata[4];
                ctrl.enable <= i_pwdata[2];
                ctrl.irq_enable <= i_pwdata[0];
            end
            if (wr && (i_paddr == TWU_OFF_MODE)) begin
                permit <= i_pwdata[3:0];
            end
            // data only while flag set, else collision
            if (data_wr && ctrl.done) begin
                data <= i_pwdata[7:0];
                ctrl.write_collision <= 1'b0;
            end else if (data_wr) begin
                ctrl.write_collision <= 1'b1;
            end
            if (ev_done) begin
                ctrl.done <= 1'b1;
            end
        end
    end

    // bus busy between a seen START and a seen STOP
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            bus_busy <= 1'b0;
        end else if (i_ce) begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
            if (scl_in && scl_prev && sda_prev && !sda_in) begin
                bus_busy <= 1'b1;
            end else if (scl_in && scl_prev && !sda_prev && sda_in) begin
                bus_busy <= 1'b0;
            end
        end
    end

    // bus sequencer; quarter-period timer paces every scl change while enabled
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
            code <= TWU_SC_IDLE[7:3];
            cur_mode <= TWU_MODE_NONE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            timer <= 10'h000;
            step <= 2'b00;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            ev_done <= 1'b0;
            ev_stop <= 1'b0;
            addr_byte <= 1'b0;
            rep <= 1'b0;
            ack <= 1'b0;
        end else if (i_ce) begin
            ev_done <= 1'b0;
            ev_stop <= 1'b0;
            if (!tick) begin
                timer <= timer - 10'h001;
            end
            // disabled unit lets go of the bus
            if (!ctrl.enable) begin
                state <= ST_IDLE;
                scl_low <= 1'b0;
                sda_low <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        scl_low <= 1'b0;
                        sda_low <= 1'b0;
                        cur_mode <= TWU_MODE_NONE;
                        // START only once flag clear and bus free
                        if (ctrl.start && !ctrl.done && !ev_done
                            && master_ok && !bus_busy) begin
                            sda_low <= 1'b1;
                            timer <= TWU_HALF;
                            rep <= 1'b0;
                            state <= ST_START;
                        end
                    end
                    ST_START: begin
                        // flag and code once START is out
                        if (tick) begin
                            scl_low <= 1'b1;
                            ev_done <= 1'b1;
                            code <= rep ? TWU_SC_RSTART[7:3]
                                        : TWU_SC_START[7:3];
                            addr_byte <= 1'b1;
                            state <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        // wait with scl low until flag cleared
                        if (!ctrl.done && !ev_done) begin
                            timer <= TWU_QTR;
                            step <= 2'b00;
                            if (ctrl.stop) begin
                                sda_low <= 1'b1;
                                state <= ST_STOP;
                            end else if (ctrl.start) begin
                                sda_low <= 1'b0;
                                state <= ST_RSTART;
                            end else begin
                                shift <= data;
                                bit_cnt <= 4'h0;
                                // direction bit selects the master mode
                                if (addr_byte) begin
                                    cur_mode <= data[0] ? 4'b0010 : 4'b0001;
                                end
                                state <= ST_LOW;
                            end
                        end
                    end
                    ST_RSTART: begin
                        // release scl, honour stretching, then START
                        if (step == 2'b00 && tick) begin
                            scl_low <= 1'b0;
                            timer <= TWU_QTR;
                            step <= 2'b01;
                        end else if (step == 2'b01 && !scl_in) begin
                            timer <= TWU_QTR;
                        end else if (step == 2'b01 && tick) begin
                            sda_low <= 1'b1;
                            timer <= TWU_HALF;
                            rep <= 1'b1;
                            state <= ST_START;
                        end
                    end
                    ST_LOW: begin
                        // msb first, ack slot left released
                        if (step == 2'b00 && tick) begin
                            sda_low <= (bit_cnt == TWU_ACK_BIT) ? 1'b0
                                                                : !shift[7];
                            timer <= TWU_QTR;
                            step <= 2'b01;
                        end else if (step == 2'b01 && tick) begin
                            scl_low <= 1'b0;
                            timer <= TWU_HALF;
                            state <= ST_HIGH;
                        end
                    end
                    ST_HIGH: begin
                        if (!scl_in) begin
                            timer <= TWU_HALF;
                        end else if (timer == TWU_QTR) begin
                            // released one read back low loses the bus
                            if (bit_cnt != TWU_ACK_BIT && !sda_low && !sda_in)
                            begin
                                sda_low <= 1'b0;
                                code <= TWU_SC_ARB_LOST[7:3];
                                ev_done <= 1'b1;
                                state <= ST_IDLE;
                            end
                            ack <= !sda_in;
                        end else if (tick) begin
                            scl_low <= 1'b1;
                            step <= 2'b00;
                            timer <= TWU_QTR;
                            if (bit_cnt == TWU_ACK_BIT) begin
                                ev_done <= 1'b1;
                                addr_byte <= 1'b0;
                                if (addr_byte) begin
                                    code <= ack ? TWU_SC_ADDR_ACK[7:3]
                                                : TWU_SC_ADDR_NACK[7:3];
                                end else begin
                                    code <= ack ? TWU_SC_DATA_ACK[7:3]
                                                : TWU_SC_DATA_NACK[7:3];
                                end
                                state <= ST_HOLD;
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                                shift <= {shift[6:0], 1'b0};
                                state <= ST_LOW;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (step == 2'b00 && tick) begin
                            scl_low <= 1'b0;
                            timer <= TWU_QTR;
                            step <= 2'b01;
                        end else if (step == 2'b01 && !scl_in) begin
                            timer <= TWU_QTR;
                        end else if (step == 2'b01 && tick) begin
                            sda_low <= 1'b0;
                            timer <= TWU_QTR;
                            step <= 2'b10;
                        end else if (step == 2'b10 && tick) begin
                            ev_stop <= 1'b1;
                            code <= TWU_SC_IDLE[7:3];
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    chk_hold_scl_low: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (state == ST_HOLD && ctrl.enable) |-> o_scl_oe)
        else $error("scl released while waiting for software");

    chk_flag_suspends: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (state == ST_HOLD && ctrl.done && ctrl.enable && i_ce
         && !wr) |=> state == ST_HOLD)
        else $error("sequencer left hold while flag set");

    chk_start_code: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        ($rose(ctrl.done) && $past(state, 2) == ST_START)
        |-> (code == TWU_SC_START[7:3] || code == TWU_SC_RSTART[7:3]))
        else $error("wrong code after start");

    chk_addr_code: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (ev_done && $past(state) == ST_HIGH && $past(addr_byte))
        |-> (code == TWU_SC_ADDR_ACK[7:3] || code == TWU_SC_ADDR_NACK[7:3]
             || code == TWU_SC_ARB_LOST[7:3]))
        else $error("wrong code after address byte");

    chk_data_collision: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (data_wr && !ctrl.done) |=> (ctrl.write_collision
         && data == $past(data)))
        else $error("data write with flag low not refused");

    chk_stop_no_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (state == ST_STOP && step == 2'b10 && tick && i_ce
         && ctrl.enable) |=> ##1 (!ctrl.stop && state == ST_IDLE
         && !ev_done))
        else $error("stop did not end cleanly");

    chk_flag_clear: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (wr && i_paddr == TWU_OFF_CTRL && i_pwdata[7] && !ev_done)
        |=> !ctrl.done)
        else $error("flag not cleared by writing one");

    chk_arb_release: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        (ev_done && code == TWU_SC_ARB_LOST[7:3]) |-> (state == ST_IDLE
         && !o_sda_oe) ##1 ctrl.done)
        else $error("bus not released after lost arbitration");

    chk_irq_follows: assert property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        ($rose(ctrl.done) && ctrl.irq_enable) |-> o_irq [*1] ##1
        (o_irq || !ctrl.done || !ctrl.irq_enable))
        else $error("interrupt request missing");

    cov_start_sent: cover property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        ev_done && code == TWU_SC_START[7:3]);

    cov_data_acked: cover property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        ev_done && code == TWU_SC_DATA_ACK[7:3]);

    cov_stop_sent: cover property (@(posedge i_ref_clk)
        disable iff (!i_arst_n)
        ev_stop);

endmodule : twu_master_tx
`default_nettype wire

// ### hdl/twu_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one bus pin.
 * Assumes the pin is asynchronous to i_ref_clk and idles high.
 */
`timescale 1ns/1ps
`default_nettype none

module twu_pin_sync (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // raw pin and filtered level
    input wire logic i_pin,
    output logic o_level
);

    logic s1;
    logic s2;
    logic s3;

    // chain; only s2 reads s1, the filter looks at s2 and s3 only
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else if (i_ce) begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // level follows only when the last two stages agree
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= 1'b1;
        end else if (i_ce && (s2 == s3)) begin
            o_level <= s3;
        end
    end

endmodule : twu_pin_sync
`default_nettype wire

// ### hdl/twu_pkg.sv
/*
 * Shared constants and types for the two-wire master transmitter:
 * register offsets, reset values, status codes, bus timing, the
 * control register layout and the sequencer states.
 * Assumes a 125 MHz register clock and a 100 kHz bus rate.
 */
package twu_pkg;

    // register byte offsets on the APB slave
    localparam logic [7:0] TWU_OFF_CTRL = 8'h00;
    localparam logic [7:0] TWU_OFF_STATUS = 8'h04;
    localparam logic [7:0] TWU_OFF_DATA = 8'h08;
    localparam logic [7:0] TWU_OFF_MODE = 8'h0C;

    // reset values
    localparam logic [7:0] TWU_CTRL_RST = 8'h00;
    localparam logic [7:0] TWU_DATA_RST = 8'hFF;
    localparam logic [3:0] TWU_PERMIT_RST = 4'h1;
    localparam logic [3:0] TWU_MODE_NONE = 4'h0;

    // allowed-mode and current-mode bit positions
    localparam int TWU_MODE_MT = 0;
    localparam int TWU_MODE_MR = 1;

    // status codes, low three bits always zero
    localparam logic [7:0] TWU_SC_START = 8'h08;
    localparam logic [7:0] TWU_SC_RSTART = 8'h10;
    localparam logic [7:0] TWU_SC_ADDR_ACK = 8'h18;
    localparam logic [7:0] TWU_SC_ADDR_NACK = 8'h20;
    localparam logic [7:0] TWU_SC_DATA_ACK = 8'h28;
    localparam logic [7:0] TWU_SC_DATA_NACK = 8'h30;
    localparam logic [7:0] TWU_SC_ARB_LOST = 8'h38;
    localparam logic [7:0] TWU_SC_IDLE = 8'hF8;

    // bus timing: quarter of an scl period, rounded up to clocks
    localparam int TWU_CLK_NS = 8;
    localparam int TWU_SCL_QTR_NS = 2500;
    localparam int TWU_QTR_CYC = (TWU_SCL_QTR_NS + TWU_CLK_NS - 1) / TWU_CLK_NS;
    localparam logic [9:0] TWU_QTR = 10'(TWU_QTR_CYC);
    localparam logic [9:0] TWU_HALF = 10'(2 * TWU_QTR_CYC);
    localparam logic [3:0] TWU_ACK_BIT = 4'h8;

    // control register layout, msb first
    typedef struct packed {
        logic done;
        logic ack_enable;
        logic start;
        logic stop;
        logic write_collision;
        logic enable;
        logic unused;
        logic irq_enable;
    } twu_ctrl_s;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_START = 7'b000_0010,
        ST_HOLD = 7'b000_0100,
        ST_RSTART = 7'b000_1000,
        ST_LOW = 7'b001_0000,
        ST_HIGH = 7'b010_0000,
        ST_STOP = 7'b100_0000
    } twu_state_e;

endpackage : twu_pkg

// ### test/twu_master_tx_bench.sv
/* Bench for twu_master_tx: reset rows, a write transfer, stop.
   Assumes the slave model and pull-ups on both lines. */
`timescale 1ns/1ps
`default_nettype none
module twu_master_tx_bench;
    import twu_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] e;} twu_row_s;
    twu_row_s rows[5];
    logic clk, rst_n, psel, pen, pwr, slv_oe, ack_en, err;
    logic scl_oe, sda_oe, irq, rdy, slverr, scl_o, sda_o;
    logic [7:0] addr, rx;
    logic [31:0] wd, prd, rd;
    int n_mismatch, samples_checked, cyc;
    // wired-and with pull-ups
    wire scl_ln = ~scl_oe;
    wire sda_ln = ~(sda_oe | slv_oe);

    twu_master_tx DUT (.i_ref_clk(clk), .i_arst_n(rst_n), .i_ce(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
        .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(slverr),
        .i_scl(scl_ln), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_ln),
        .o_sda(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
    twu_slave_model slave (.i_scl(scl_ln), .i_sda(sda_ln),
        .i_ack_en(ack_en), .o_sda_oe(slv_oe), .o_rx_byte(rx));

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // hang guard, the transfers need about 40k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    // apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1;
        // pready is tied high here, so this wait ends at the first edge
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd = prd;
        err = slverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    // write control, wait for the flag, then look at bus and status
    task automatic step(input logic [7:0] c, input logic [7:0] s);
        apb(1, TWU_OFF_CTRL, {24'h00_0000, c});
        // the flag clear landed at the last apb edge; this edge keeps the old flag from being seen
        @(posedge clk);
        while (irq !== 1'b1) begin
            @(posedge clk);
        end
        repeat (50) @(posedge clk);
        check("scl_held", scl_ln, 1'b0);
        apb(0, TWU_OFF_STATUS, 32'h0000_0000);
        check("status", rd, {24'h00_0000, s});
    endtask : step
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rows = '{'{TWU_OFF_CTRL, 0}, '{TWU_OFF_STATUS, 32'h0000_00F8},
            '{TWU_OFF_DATA, 32'h0000_00FF}, '{TWU_OFF_MODE, 1}, '{8'h10, 0}};
        {rst_n, psel, pen, pwr, addr, wd} = 0;
        ack_en = 1;
        cyc = 0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            check("reset_reg", rd, rows[i].e);
        end
        check("slverr", err, 1'b1);
        // data write with flag low is dropped
        apb(1, TWU_OFF_DATA, 32'h0000_0055);
        apb(0, TWU_OFF_CTRL, 0);
        check("collision", rd, 32'h0000_0008);
        apb(0, TWU_OFF_DATA, 0);
        check("data_kept", rd, 32'h0000_00FF);
        step(8'hA5, TWU_SC_START);
        apb(1, TWU_OFF_CTRL, 32'h0000_0005);
        repeat (400) @(posedge clk);
        check("flag_kept", irq, 1'b1);
        apb(1, TWU_OFF_DATA, 32'h0000_00A6);
        step(8'h85, TWU_SC_ADDR_ACK);
        check("addr_byte", rx, 8'hA6);
        apb(0, TWU_OFF_MODE, 0);
        check("mode", rd, 32'h0000_0011);
        ack_en <= 0;
        apb(1, TWU_OFF_DATA, 32'h0000_003C);
        step(8'h85, TWU_SC_DATA_NACK);
        check("data_byte", rx, 8'h3C);
        step(8'hA5, TWU_SC_RSTART);
        apb(1, TWU_OFF_DATA, 32'h0000_00A6);
        step(8'h85, TWU_SC_ADDR_NACK);
        apb(1, TWU_OFF_CTRL, 32'h0000_0095);
        // poll until the stop request has cleared itself
        do begin
            apb(0, TWU_OFF_CTRL, 0);
        end while (rd[4] !== 1'b0);
        check("stop_clear", rd[4], 1'b0);
        check("no_flag", irq, 1'b0);
        check("released", {scl_oe, sda_oe}, 2'b00);
        check("pads_low", {scl_o, sda_o}, 2'b00);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        check("reset_lines", {scl_oe, sda_oe, irq}, 3'b000);
        rst_n <= 1;
        apb(0, TWU_OFF_STATUS, 0);
        check("status_rst", rd, 32'h0000_00F8);
        // no master mode permitted: a start request must not reach the bus
        apb(1, TWU_OFF_MODE, 0);
        apb(1, TWU_OFF_CTRL, 32'h0000_00A5);
        repeat (700) @(posedge clk);
        check("no_start", {sda_oe, scl_oe, irq}, 3'b000);
        tally_and_finish();
    end
endmodule : twu_master_tx_bench
`default_nettype wire

// ### test/twu_slave_model.sv
/* Behavioural slave receiver on the two-wire bus.
   Assumes pulled-up lines resolved by the bench. */
`timescale 1ns/1ps
`default_nettype none
module twu_slave_model (
    // bus levels
    input wire logic i_scl,
    input wire logic i_sda,
    // ack choice, sda pull, last byte
    input wire logic i_ack_en,
    output logic o_sda_oe,
    output logic [7:0] o_rx_byte
);
    int n;
    logic [7:0] sh;
    initial begin
        o_sda_oe = 0;
        o_rx_byte = 0;
        sh = 0;
        n = 0;
    end
    // start or repeated start restarts the byte
    always @(negedge i_sda) if (i_scl === 1'b1) n = 0;
    always @(posedge i_scl) begin
        if (n < 8) sh = {sh[6:0], i_sda};
        n = n + 1;
    end
    // ack is low, nack leaves the line high
    always @(negedge i_scl) begin
        if (n == 8) begin
            o_rx_byte = sh;
            o_sda_oe = i_ack_en;
        end else if (n == 9) begin
            o_sda_oe = 0;
            n = 0;
        end
    end
endmodule : twu_slave_model
`default_nettype wire
